/* odc_params.svh */
// Purpose: Named constants for the octal converter control core
// Assumes: Included by odc_core.sv and by the bench
// Notes:   Bit positions refer to the 16-bit serial control word
`ifndef ODC_PARAMS_SVH
`define ODC_PARAMS_SVH
// Serial word layout
`define ODC_LAST_BIT   4'hf
`define ODC_BIT_CTL    15
`define ODC_ADDR_HI    14
`define ODC_ADDR_LO    12
`define ODC_MODE_HI    14
`define ODC_MODE_LO    13
`define ODC_BIT_FULL   12
`define ODC_DATA_MSB   11
`define ODC_PD_HI      7
`define ODC_REF_HI     5
`define ODC_LD_HI      1
// Control modes
`define ODC_MODE_REF   2'h0
`define ODC_MODE_LD    2'h1
`define ODC_MODE_PD    2'h2
`define ODC_MODE_RST   2'h3
// Load modes
`define ODC_LD_TRANSP  2'h0
`define ODC_LD_LATCH   2'h1
`define ODC_LD_SINGLE  2'h2
`define ODC_LD_RSVD    2'h3
// Power-on values
`define ODC_PD_RESET   8'h00
`define ODC_REF_RESET  6'h00
`define ODC_CTRL_RESET 1'h1
// Register map (byte addresses; pages are address bits 7:5)
`define ODC_REG_CTRL   8'h00
`define ODC_REG_STAT   8'h04
`define ODC_PAGE_OUT   3'h1
`define ODC_PAGE_IN    3'h2
`endif

/* odc_pkg.sv */
// Purpose: Types shared by the converter control core
// Assumes: Constants come from odc_params.svh
// Notes:   Types only, no logic
package odc_pkg;
  // Reference and gain settings, one bit per channel group (EH, AD)
  typedef struct packed {
    logic [1:0] gain;
    logic [1:0] bufEn;
    logic [1:0] vddRef;
  } odc_refcfg_s;
  // Serial pins as sampled
  typedef struct packed {
    logic sclk;
    logic din;
    logic frame_n;
    logic load_n;
  } odc_pins_s;
  // Serial link states
  typedef enum {LK_IDLE, LK_SHIFT, LK_DONE} odc_link_e;
endpackage : odc_pkg

/* odc_core.sv */
// Purpose: Control core of an octal converter with a 3-wire serial link
// Assumes: Link pins are asynchronous to mclk and much slower than it
// Notes:   Wishbone slave gives visibility of codes and state
//
// Notes on behaviour
// [RQ1] Power-down word powers down flagged channels
// [RQ2] Reset with bit 12 low clears data
// [RQ3] Reset with bit 12 high clears everything
// [RQ4] Link active from frame fall to rise
// [RQ5] Host keeps load pin high for software
// [RQ6] Host leaves latched mode for pin updates
// [RQ7] Data and reference settings double buffered
// [RQ8] Outputs update after 16th edge if pin low
// [RQ9] Load pin low copies input registers out
// [RQ10] Complete word writes addressed input register
// [RQ11] Latched holds; transparent or pin low pass
// [RQ12] Host may update all with last write
// [RQ13] Only channels written since last update copy
// [RQ14] Host keeps frame low across byte pairs
// [RQ15] Host sends most significant bit first
// [RQ16] Host changes data on rising clock edge
// [RQ17] Host uses clock polarity 0, phase 1
// [RQ18] Frame rise before 16 edges aborts word
// [RQ19] Bit 15 selects data or control word
// [RQ20] Load codes transparent, latched, single, reserved
// [RQ21] Mode 00 sets gain, buffer, supply reference
// [RQ22] Reserved load code ignored entirely
// [RQ23] Pins synchronised before use
`timescale 1ns/1ps
`include "odc_params.svh"

module odc_core #(
  parameter int CODE_W = 12              // Converter resolution
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  // Serial link pins
  input  wire logic                          sclkPin,
  input  wire logic                          dinPin,
  input  wire logic                          frameSel_n,
  input  wire logic                          load_outputs_n,
  // Wishbone slave
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [7:0]                    adr_i,
  input  wire logic [31:0]                   dat_i,
  input  wire logic [3:0]                    sel_i,
  output logic      [31:0]                   dat_o,
  output logic                               ack_o,
  // Converter side
  output logic      [7:0][CODE_W-1:0]        dacCode,
  output logic      [7:0]                    powerDown,
  output odc_pkg::odc_refcfg_s               refCfg,
  output logic                               linkActive
);
  import odc_pkg::*;

  // Refuse resolutions the word cannot carry
  if (CODE_W < 1 || CODE_W > 12)
  begin : g_chk
    $error("CODE_W must be 1 to 12");
  end

  // Control word with a given mode
  function automatic logic isMode(input logic [15:0] w,
                                  input logic [1:0]  m);
    isMode = w[`ODC_BIT_CTL] &&
             (w[`ODC_MODE_HI:`ODC_MODE_LO] == m);
  endfunction : isMode

  localparam odc_pins_s PIN_IDLE = '{sclk: 1'b0, din: 1'b0,
                                     frame_n: 1'b1, load_n: 1'b1};

  // Synchroniser stages; pinA is read only by pinB
  odc_pins_s pinA;                       // First stage
  odc_pins_s pinB;                       // Safe copy
  odc_pins_s pinC;                       // Previous, for edges
  logic      sclkFall;                   // Falling serial clock
  logic      frameLow;                   // Frame selected

  // Two flops per pin before any use
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pinA <= PIN_IDLE;
      pinB <= PIN_IDLE;
      pinC <= PIN_IDLE;
    end
    else
    begin
      pinA <= '{sclkPin, dinPin, frameSel_n, load_outputs_n}; // RQ23
      pinB <= pinA;
      pinC <= pinB;
    end
  end

  assign sclkFall = pinC.sclk && !pinB.sclk;
  assign frameLow = !pinB.frame_n;

  // Link state
  odc_link_e   linkSt, next_linkSt;       // Framing state
  logic [3:0]  bitCnt, next_bitCnt;       // Edges seen in frame
  logic [14:0] shift, next_shift;         // Bits so far
  logic        rxValid, next_rxValid;     // Word complete pulse
  logic [15:0] rxWord, next_rxWord;       // Completed word
  logic        next_linkActive;           // Input stage on
  logic        linkEnable, next_linkEnable; // Software gate

  // Shift on falling edges, MSB first
  always_comb
  begin
    next_linkSt     = linkSt;
    next_bitCnt     = bitCnt;
    next_shift      = shift;
    next_rxValid    = 1'b0;
    next_rxWord     = rxWord;
    next_linkActive = linkActive;
    unique case (linkSt)
      LK_IDLE:
      begin
        // Disabled link ignores whole frames
        if (frameLow && linkEnable)
        begin
          next_linkSt     = LK_SHIFT;
          next_bitCnt     = 4'h0;
          next_linkActive = 1'b1;          // RQ4
        end
      end
      LK_SHIFT:
      begin
        if (!frameLow)
        begin
          // Short frame: word dropped, nothing written
          next_linkSt     = LK_IDLE;       // RQ18
          next_linkActive = 1'b0;          // RQ4
        end
        else if (sclkFall)
        begin
          next_shift  = {shift[13:0], pinB.din};
          next_bitCnt = bitCnt + 4'h1;
          if (bitCnt == `ODC_LAST_BIT)
          begin
            next_rxValid = 1'b1;           // RQ8
            next_rxWord  = {shift, pinB.din};
            next_linkSt  = LK_DONE;
          end
        end
      end
      LK_DONE:
      begin
        // Extra edges after the 16th are ignored
        if (!frameLow)
        begin
          next_linkSt     = LK_IDLE;
          next_linkActive = 1'b0;          // RQ4
        end
      end
    endcase
  end

  // Link registers
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      linkSt     <= LK_IDLE;
      bitCnt     <= 4'h0;
      shift      <= 15'h0000;
      rxValid    <= 1'b0;
      rxWord     <= 16'h0000;
      linkActive <= 1'b0;
    end
    else
    begin
      linkSt     <= next_linkSt;
      bitCnt     <= next_bitCnt;
      shift      <= next_shift;
      rxValid    <= next_rxValid;
      rxWord     <= next_rxWord;
      linkActive <= next_linkActive;
    end
  end

  // Converter state
  logic [7:0][CODE_W-1:0] inCode, next_inCode;   // Input registers
  logic [7:0][CODE_W-1:0] next_dacCode;          // Output registers
  logic [7:0]             dirty, next_dirty;     // Written, not loaded
  odc_refcfg_s            refStage, next_refStage; // Staged settings
  odc_refcfg_s            next_refCfg;
  logic [1:0]             ldMode, next_ldMode;   // Load mode
  logic [7:0]             next_powerDown;
  logic                   singleUpd, next_singleUpd; // One-shot load
  logic                   transparent;           // Outputs follow inputs
  logic [2:0]             chan;                  // Addressed channel

  assign transparent = (ldMode == `ODC_LD_TRANSP) ||
                       !pinB.load_n || singleUpd;      // RQ11
  assign chan = rxWord[`ODC_ADDR_HI:`ODC_ADDR_LO];

  // Command decode and double buffer transfer
  always_comb
  begin
    next_inCode    = inCode;
    next_dacCode   = dacCode;
    next_dirty     = dirty;
    next_refStage  = refStage;
    next_refCfg    = refCfg;
    next_ldMode    = ldMode;
    next_powerDown = powerDown;
    next_singleUpd = 1'b0;
    // Load event copies only channels written since last load
    if (transparent)
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (dirty[i])
        begin
          next_dacCode[i] = inCode[i];       // RQ9 RQ13
          next_dirty[i]   = 1'b0;
        end
      end
      next_refCfg = refStage;                // RQ7
    end
    if (rxValid)
    begin
      if (!rxWord[`ODC_BIT_CTL])
      begin
        // Data word; a write in a load cycle stays dirty
        next_inCode[chan] =
          rxWord[`ODC_DATA_MSB -: CODE_W];   // RQ10 RQ19
        next_dirty[chan]  = 1'b1;
      end
      else if (isMode(rxWord, `ODC_MODE_REF))
        next_refStage = rxWord[`ODC_REF_HI:0]; // RQ21 RQ7
      else if (isMode(rxWord, `ODC_MODE_LD))
      begin
        // Reserved code changes nothing
        if (rxWord[`ODC_LD_HI:0] != `ODC_LD_RSVD) // RQ22
        begin
          next_ldMode    = rxWord[`ODC_LD_HI:0];  // RQ20
          next_singleUpd =
            (rxWord[`ODC_LD_HI:0] == `ODC_LD_SINGLE);
        end
      end
      else if (isMode(rxWord, `ODC_MODE_PD))
        next_powerDown = rxWord[`ODC_PD_HI:0];   // RQ1
      else
      begin
        // Reset commands win over any pending load
        next_inCode  = '0;                       // RQ2
        next_dacCode = '0;
        next_dirty   = 8'h00;
        if (rxWord[`ODC_BIT_FULL])
        begin
          next_refStage  = `ODC_REF_RESET;       // RQ3
          next_refCfg    = `ODC_REF_RESET;
          next_ldMode    = `ODC_LD_LATCH;
          next_powerDown = `ODC_PD_RESET;
        end
      end
    end
  end

  // Converter registers; power-on state is latched, all zero
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      inCode    <= '0;
      dacCode   <= '0;
      dirty     <= 8'h00;
      refStage  <= `ODC_REF_RESET;
      refCfg    <= `ODC_REF_RESET;
      ldMode    <= `ODC_LD_LATCH;
      powerDown <= `ODC_PD_RESET;
      singleUpd <= 1'b0;
    end
    else
    begin
      inCode    <= next_inCode;
      dacCode   <= next_dacCode;
      dirty     <= next_dirty;
      refStage  <= next_refStage;
      refCfg    <= next_refCfg;
      ldMode    <= next_ldMode;
      powerDown <= next_powerDown;
      singleUpd <= next_singleUpd;
    end
  end

  // Bus slave
  logic        next_ack;                 // Answer next cycle
  logic [31:0] next_dat;                 // Read data
  logic [31:0] readWord;                 // Decoded register

  // Read decode; unmapped reads return zero
  always_comb
  begin
    readWord = 32'h0000_0000;
    if (adr_i == `ODC_REG_CTRL)
      readWord = 32'(linkEnable);
    else if (adr_i == `ODC_REG_STAT)
      readWord = {7'h00, dirty, linkActive, refCfg, ldMode, powerDown};
    else if (adr_i[1:0] == 2'h0 && adr_i[7:5] == `ODC_PAGE_OUT)
      readWord = 32'(dacCode[adr_i[4:2]]);
    else if (adr_i[1:0] == 2'h0 && adr_i[7:5] == `ODC_PAGE_IN)
      readWord = 32'(inCode[adr_i[4:2]]);
  end

  // Ack one cycle after request; write lands on the ack edge
  always_comb
  begin
    next_ack        = cyc_i && stb_i && !ack_o;
    next_dat        = next_ack ? readWord : dat_o;
    next_linkEnable = linkEnable;
    if (ack_o && cyc_i && stb_i && we_i && sel_i[0] &&
        adr_i == `ODC_REG_CTRL)
      next_linkEnable = dat_i[0];
  end

  // Bus registers
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ack_o      <= 1'b0;
      dat_o      <= 32'h0000_0000;
      linkEnable <= `ODC_CTRL_RESET;
    end
    else
    begin
      ack_o      <= next_ack;
      dat_o      <= next_dat;
      linkEnable <= next_linkEnable;
    end
  end

  // Checks
  pd_update_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ1
    rxValid && isMode(rxWord, `ODC_MODE_PD)
    |=> powerDown == $past(rxWord[`ODC_PD_HI:0]))
    else $error("power-down bits not taken");

  data_reset_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ2
    rxValid && isMode(rxWord, `ODC_MODE_RST)
    |=> dacCode == '0 && inCode == '0 && dirty == 8'h00)
    else $error("data reset incomplete");

  full_reset_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ3
    rxValid && isMode(rxWord, `ODC_MODE_RST) && rxWord[`ODC_BIT_FULL]
    |=> ldMode == `ODC_LD_LATCH && powerDown == 8'h00 && refCfg == '0)
    else $error("control reset incomplete");

  link_idle_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ4
    linkActive && !frameLow |=> !linkActive)
    else $error("input stage left on");

  latched_hold_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ11
    !transparent && !rxValid |=> $stable(dacCode))
    else $error("latched outputs moved");

  word_abort_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ18
    linkSt == LK_SHIFT && !frameLow |=> !rxValid ##1 !rxValid)
    else $error("short frame produced a word");

  chan_write_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ10
    rxValid && !rxWord[`ODC_BIT_CTL]
    |=> inCode[$past(chan)] == $past(rxWord[`ODC_DATA_MSB -: CODE_W])
        && dirty[$past(chan)])
    else $error("channel write lost");

  ld_reserved_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ22
    rxValid && isMode(rxWord, `ODC_MODE_LD) &&
    rxWord[`ODC_LD_HI:0] == `ODC_LD_RSVD
    |=> $stable(ldMode) && !singleUpd)
    else $error("reserved load code acted");

  pin_load_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ9
    !pinB.load_n && dirty[0] && !rxValid
    |=> dacCode[0] == $past(inCode[0]))
    else $error("load pin did not copy");

  clean_skip_a: assert property (@(posedge mclk) disable iff (!rst_b) // RQ13
    !dirty[1] && !rxValid |=> $stable(dacCode[1]))
    else $error("clean channel reloaded");

endmodule : odc_core

/* odc_host.sv */
// Purpose: Host serial port model driving the converter link
// Assumes: Clock polarity 0, data valid at falling edge
// Notes:   Link clock stands low between frames
`timescale 1ns/1ps

module odc_host (
  // Serial pins toward the core
  output logic sclkPin,
  output logic dinPin,
  output logic frameSel_n
);
  // Idle levels: frame high, clock low
  initial
  begin
    sclkPin    = 1'b0;
    dinPin     = 1'b0;
    frameSel_n = 1'b1;
  end

  // One frame; fewer than 16 falls aborts, split pauses mid-word
  task automatic send(input logic [15:0] w, input int falls, input bit split);
    frameSel_n = 1'b0;
    #20;
    for (int i = 0; i < falls; i++)
    begin
      sclkPin = 1'b1;
      dinPin  = w[15 - i];
      #32;
      sclkPin = 1'b0;
      #32;
      // Byte-wide hosts keep the frame low across the gap
      if (split && i == 7)
        #150;
    end
    #10;
    frameSel_n = 1'b1;
    // Released data line must not look like a held bit
    dinPin = ~dinPin;
    #40;
  endtask : send
endmodule : odc_host

/* octal_dac_update_control_bench.sv */
// Purpose: Self-checking bench for the converter control core
// Assumes: Host model drives the link, bench drives bus and load pin
// Notes:   Expectations come from a register model kept here
`timescale 1ns/1ps
`include "odc_params.svh"

module octal_dac_update_control_bench;
  import odc_pkg::*;
  // Clock, reset, load pin and bus
  logic             mclk = 1'b0;
  logic             rst_b = 1'b0;
  logic             loadOutputs_n = 1'b1;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [7:0]       adr = 8'h00;
  logic [31:0]      datW = 32'h0;
  logic [3:0]       sel = 4'h0;
  logic [31:0]      datR;
  logic             ack;
  // Core outputs and link pins
  logic [7:0][11:0] dacCode;
  logic [7:0]       powerDown;
  odc_refcfg_s      refCfg;
  logic             linkActive;
  logic             sclk;
  logic             din;
  logic             frame_n;
  // Expected state
  logic [11:0]      expIn [8];
  logic [11:0]      expOut [8];
  logic [7:0]       dirty, expPd;
  logic [5:0]       expRef, expStage;
  logic [1:0]       expMode;
  logic [31:0]      q;
  int               num_errors = 0;
  int               num_checks = 0;

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  odc_core #(.CODE_W(12)) i_odc_core (
    .mclk(mclk), .rst_b(rst_b), .sclkPin(sclk), .dinPin(din),
    .frameSel_n(frame_n), .load_outputs_n(loadOutputs_n),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(datW),
    .sel_i(sel), .dat_o(datR), .ack_o(ack), .dacCode(dacCode),
    .powerDown(powerDown), .refCfg(refCfg), .linkActive(linkActive)
  );

  odc_host i_odc_host (.sclkPin(sclk), .dinPin(din), .frameSel_n(frame_n));

  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    datW <= d;
    sel  <= 4'h1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      num_errors++;
      report_and_stop();
    end
    r = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Copy dirty channels and staged reference settings
  task do_load;
    for (int i = 0; i < 8; i++)
      if (dirty[i])
        expOut[i] = expIn[i];
    dirty  = 8'h00;
    expRef = expStage;
  endtask : do_load

  // Expected effect of one complete word
  task automatic model(input logic [15:0] w);
    if (!w[15])
    begin
      expIn[w[14:12]] = w[11:0];
      dirty[w[14:12]] = 1'b1;
    end
    else
      case (w[14:13])
        2'h0: expStage = w[5:0];
        2'h1: if (w[1:0] != 2'h3) expMode = w[1:0];
        2'h2: expPd = w[7:0];
        default:
        begin
          for (int i = 0; i < 8; i++)
          begin
            expIn[i]  = 12'h000;
            expOut[i] = 12'h000;
          end
          dirty = 8'h00;
          if (w[12])
          begin
            {expStage, expRef, expPd, expMode} = {6'h00, 6'h00, 8'h00, 2'h1};
          end
        end
      endcase
    if (expMode == 2'h0 || (w[15:13] == 3'h5 && w[1:0] == 2'h2))
      do_load();
  endtask : model

  task automatic xfer(input logic [15:0] w, input int f = 16, input bit s = 0);
    i_odc_host.send(w, f, s);
    if (f == 16)
      model(w);
  endtask : xfer

  task pulse_load;
    @(posedge mclk);
    loadOutputs_n <= 1'b0;
    repeat (3) @(posedge mclk);
    loadOutputs_n <= 1'b1;
    repeat (6) @(posedge mclk);
    do_load();
  endtask : pulse_load

  task automatic check_all;
    logic [31:0] r;
    for (int i = 0; i < 8; i++)
    begin
      chk("dacCode", {20'h0, expOut[i]}, {20'h0, dacCode[i]});
      wb(1'b0, 8'h40 + 8'(4 * i), 32'h0, r);
      chk("inCode", {20'h0, expIn[i]}, r);
    end
    chk("powerDown", {24'h0, expPd}, {24'h0, powerDown});
    chk("refCfg", {26'h0, expRef}, {26'h0, refCfg});
    wb(1'b0, `ODC_REG_STAT, 32'h0, r);
    chk("status", {7'h0, dirty, 1'b0, expRef, expMode, expPd}, r);
  endtask : check_all

  function automatic logic [15:0] dw(input int ch, input logic [11:0] c);
    return {1'b0, 3'(ch), c};
  endfunction : dw

  function automatic logic [15:0] cw(input logic [1:0] m, input int p);
    return {1'b1, m, 13'(p)};
  endfunction : cw

  // Main sequence
  initial
  begin
    void'($urandom(32'h3b908dd3));
    for (int i = 0; i < 8; i++)
    begin
      expIn[i]  = 12'h000;
      expOut[i] = 12'h000;
    end
    {dirty, expPd, expRef, expStage, expMode} = {28'h0, 2'h1};
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    check_all();
    wb(1'b0, 8'h10, 32'h0, q);
    chk("unmapped", 32'h0, q);
    for (int i = 0; i < 8; i++)
      xfer(dw(i, 12'($urandom)), 16, i == 4);
    check_all();
    xfer(cw(2'h0, $urandom));
    check_all();
    pulse_load();
    check_all();
    xfer(dw(3, 12'hfff));
    check_all();
    pulse_load();
    check_all();
    xfer(dw(5, 12'h0a5), 15);
    check_all();
    wb(1'b1, `ODC_REG_CTRL, 32'h0, q);
    i_odc_host.send(dw(1, 12'h123), 16, 1'b0);
    wb(1'b1, `ODC_REG_CTRL, 32'h1, q);
    check_all();
    fork
      xfer(dw(1, 12'h5a5));
      #300 chk("linkActive", 32'h1, {31'h0, linkActive});
    join
    chk("linkActive", 32'h0, {31'h0, linkActive});
    @(posedge mclk);
    loadOutputs_n <= 1'b0;
    xfer(dw(6, 12'($urandom)));
    @(posedge mclk);
    loadOutputs_n <= 1'b1;
    repeat (6) @(posedge mclk);
    do_load();
    check_all();
    xfer(cw(2'h1, 3));
    check_all();
    xfer(cw(2'h1, 0));
    xfer(dw(0, 12'($urandom)));
    check_all();
    xfer(cw(2'h1, 1));
    xfer(dw(2, 12'($urandom)));
    check_all();
    xfer(cw(2'h1, 2));
    check_all();
    xfer(dw(2, 12'($urandom)));
    check_all();
    xfer(cw(2'h2, $urandom));
    check_all();
    xfer(cw(2'h3, 32'h0000));
    pulse_load();
    check_all();
    xfer(cw(2'h3, 32'h1000));
    pulse_load();
    check_all();
    report_and_stop();
  end
endmodule : octal_dac_update_control_bench
